// File: src/oc_pin_map.svh
// Register offsets, field positions, reset values for compare pin control
`ifndef OC_PIN_MAP_SVH
`define OC_PIN_MAP_SVH
`define ADDR_ACTION_CTRL   8'h00
`define ADDR_MULTI_MASK    8'h04
`define ADDR_MULTI_DATA    8'h08
`define ADDR_FLAGS         8'h0c
`define ADDR_IRQ_MASK      8'h10
`define ADDR_COUNT         8'h14
`define ADDR_DIR_CTRL      8'h18
`define ADDR_PORT_OUT      8'h1c
`define ADDR_CMP_BASE      8'h20
`define RST_ACTION_CTRL    8'h00
`define RST_MULTI          5'h00
`define RST_CMP            16'hffff
`define MULTI_LSB          3
`define DIR_BIT7_POS       7
`define NUM_CH             5
`endif

// File: src/oc_pin_pkg.sv
// Types for compare pin control
package oc_pin_pkg;
	typedef enum logic [1:0] {
		ACT_NONE   = 2'b00,
		ACT_TOGGLE = 2'b01,
		ACT_CLEAR  = 2'b10,
		ACT_SET    = 2'b11
	} pin_action_t;
endpackage

// File: src/output_compare_pin_control.sv
// Five compare channels with automatic port-A pin actions, AHB-Lite slave
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/10ps
`include "oc_pin_map.svh"
module output_compare_pin_control
	import oc_pin_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_b,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Port A timer pins 7..3
	output logic      [7:3]  portaOut,
	output logic             portaBit7OutEn_b,
	// Interrupt
	output logic             irq
);

	// ------------------------------------------------------------
	// Bus front end
	// ------------------------------------------------------------
	logic [7:0]  addrReg;
	logic        wrReg;
	logic        phaseReg;
	logic [7:0]  actionCtrl_reg;
	logic [7:3]  multiMask_reg;
	logic [7:3]  multiData_reg;
	logic [4:0]  flag_reg;
	logic [4:0]  irqMask_reg;
	logic [15:0] count_reg;
	logic        dirBit7_reg;
	logic [7:3]  pin_reg;
	logic [15:0] cmp_reg [`NUM_CH];
	logic [4:0]  inhibit_reg;
	logic [4:0]  match;
	logic [4:0]  matchDly_reg;
	logic        wrEn;
	logic [4:0]  flagClr;
	logic [7:3]  pin_next;

	// Which compare slot a word address selects; 5 means none
	function automatic logic [2:0] cmpIndex(input logic [7:0] a);
		logic [7:0] off;
		off = a - `ADDR_CMP_BASE;
		if (a >= `ADDR_CMP_BASE && off < 8'h14)
			cmpIndex = off[4:2];
		else
			cmpIndex = 3'd5;
	endfunction

	// Capture the address phase; single cycle answer, always OKAY
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			addrReg  <= 8'h00;
			wrReg    <= 1'b0;
			phaseReg <= 1'b0;
		end else if (hready) begin
			phaseReg <= hsel && htrans[1];
			wrReg    <= hsel && htrans[1] && hwrite;
			addrReg  <= haddr;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign wrEn      = wrReg;
	assign flagClr   = (wrEn && addrReg == `ADDR_FLAGS) ? hwdata[4:0] : 5'h00;

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	// Control registers; low mask/data bits are never stored
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			actionCtrl_reg <= `RST_ACTION_CTRL;
			multiMask_reg  <= `RST_MULTI;
			multiData_reg  <= `RST_MULTI;
			irqMask_reg    <= 5'h00;
			dirBit7_reg    <= 1'b0;
		end else if (wrEn) begin
			case (addrReg)
				`ADDR_ACTION_CTRL: actionCtrl_reg <= hwdata[7:0];
				`ADDR_MULTI_MASK:  multiMask_reg <= hwdata[7:3];
				`ADDR_MULTI_DATA:  multiData_reg <= hwdata[7:3];
				`ADDR_IRQ_MASK:    irqMask_reg   <= hwdata[4:0];
				`ADDR_DIR_CTRL:    dirBit7_reg <= hwdata[`DIR_BIT7_POS];
				default: ;
			endcase
		end
	end

	// Compare values; any write to a slot blocks its compare for one cycle
	// so a half-updated value cannot fire a false match
	generate
		for (genvar i = 0; i < `NUM_CH; i++) begin : g_cmp
			always_ff @(posedge clock or negedge rst_b) begin
				if (!rst_b) begin
					cmp_reg[i]     <= `RST_CMP;
					inhibit_reg[i] <= 1'b0;
				end else begin
					inhibit_reg[i] <= 1'b0;
					if (wrEn && cmpIndex(addrReg) == 3'(i)) begin
						if (hsize == 3'd0 && hwdata[8]) begin
							cmp_reg[i][15:8] <= hwdata[7:0];
							inhibit_reg[i]   <= 1'b1;
						end else begin
							cmp_reg[i]     <= hwdata[15:0];
							inhibit_reg[i] <= 1'b1;
						end
					end
				end
			end
			// Equality on every pass of the counter
			assign match[i] = (cmp_reg[i] == count_reg) &&
				!inhibit_reg[i];
		end
	endgenerate

	// Free-running counter
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			count_reg <= 16'h0000;
		else
			count_reg <= count_reg + 16'h0001;
	end

	// ------------------------------------------------------------
	// Flags and interrupt
	// ------------------------------------------------------------
	// Set beats clear so no match is lost
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			flag_reg <= 5'h00;
		else
			flag_reg <= (flag_reg & ~flagClr) | match;
	end

	assign irq = |(flag_reg & irqMask_reg);

	// Pin acts one cycle after the flag, keeping flag first
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			matchDly_reg <= 5'h00;
		else
			matchDly_reg <= match;
	end

	// ------------------------------------------------------------
	// Pin actions
	// ------------------------------------------------------------
	// Channel i (1..4) sits on pin 7-i; index 0 is the mask channel
	always_comb begin
		pin_action_t act;
		act      = ACT_NONE;
		pin_next = pin_reg;
		for (int c = 1; c < `NUM_CH; c++) begin
			act = pin_action_t'(actionCtrl_reg[9-2*c -: 2]);
			if (matchDly_reg[c]) begin
				case (act)
					ACT_NONE:   ;
					ACT_TOGGLE: pin_next[7-c] = ~pin_reg[7-c];
					ACT_CLEAR:  pin_next[7-c] = 1'b0;
					ACT_SET:    pin_next[7-c] = 1'b1;
					default:    ;
				endcase
			end
		end
		// Mask channel last so it overrides; it may share pins
		if (matchDly_reg[0]) begin
			for (int b = 3; b <= 7; b++) begin
				if (multiMask_reg[b] && (b != 7 || dirBit7_reg))
					pin_next[b] = multiData_reg[b];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			pin_reg <= 5'h00;
		else
			pin_reg <= pin_next;
	end

	assign portaOut         = pin_reg;
	assign portaBit7OutEn_b = ~dirBit7_reg;

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	// Registered read mux; unmapped addresses read zero
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			hrdata <= 32'h0000_0000;
		else if (hready && hsel && htrans[1] && !hwrite) begin
			hrdata <= 32'h0000_0000;
			case (haddr)
				`ADDR_ACTION_CTRL: hrdata[7:0] <= actionCtrl_reg;
				`ADDR_MULTI_MASK:  hrdata[7:3] <= multiMask_reg;
				`ADDR_MULTI_DATA:  hrdata[7:3] <= multiData_reg;
				`ADDR_FLAGS:       hrdata[4:0] <= flag_reg;
				`ADDR_IRQ_MASK:    hrdata[4:0] <= irqMask_reg;
				`ADDR_COUNT:       hrdata[15:0] <= count_reg;
				`ADDR_DIR_CTRL:    hrdata[7] <= dirBit7_reg;
				`ADDR_PORT_OUT:    hrdata[7:3] <= pin_reg;
				default: begin
					if (cmpIndex(haddr) != 3'd5)
						hrdata[15:0] <= cmp_reg[cmpIndex(haddr)];
				end
			endcase
		end
	end

endmodule // output_compare_pin_control

// File: tb/oc_pin_asserts.sv
// Port-level assertions for the compare pin control block
`timescale 1ns/10ps
module oc_pin_asserts (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst_b,
	// Bus side
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	// Pins and interrupt
	input wire logic [7:3]  portaOut,
	input wire logic        portaBit7OutEn_b,
	input wire logic        irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	logic       aw, ar, cmpW;
	logic [7:0] aa, act, msk, dat;
	logic [2:0] quiet;
	// Data phase of each transfer and shadows of the written registers
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			{aw, ar, aa, act, msk, dat, cmpW, quiet} <= '0;
		end else begin
			aw <= hsel && htrans[1] && hready && hwrite;
			ar <= hsel && htrans[1] && hready && !hwrite;
			aa <= haddr;
			act <= (aw && aa == 8'h00) ? hwdata[7:0] : act;
			msk <= (aw && aa == 8'h04) ? hwdata[7:0] : msk;
			dat <= (aw && aa == 8'h08) ? hwdata[7:0] : dat;
			cmpW <= cmpW || (aw && aa >= 8'h20);
			// A match already in flight may still move a pin for two cycles
			quiet <= (act == 0 && msk[7:3] == 0) ? quiet + (quiet < 4) : 3'h0;
		end
	end
	a_mask_low_zero: assert property (
		ar && aa inside {8'h04, 8'h08} |-> hrdata[2:0] == 0) else $error("low bits");
	a_action_readback: assert property (
		ar && aa == 8'h00 |-> hrdata[7:0] == act) else $error("action readback");
	a_data_readback: assert property (
		ar && aa == 8'h08 |-> hrdata[7:3] == dat[7:3]) else $error("data readback");
	a_cmp_reset_ones: assert property (
		ar && aa inside {[8'h20:8'h30]} && !cmpW |-> hrdata[15:0] == 16'hffff)
		else $error("compare reset value");
	a_dir_drives_en: assert property (
		aw && aa == 8'h18 |=> portaBit7OutEn_b == !$past(hwdata[7]))
		else $error("bit7 enable");
	a_pin7_input_hold: assert property (
		portaBit7OutEn_b && $past(portaBit7OutEn_b) |-> $stable(portaOut[7]))
		else $error("bit7 moved as input");
	a_irq_sticky: assert property (
		irq && !aw && !$past(aw) |=> irq) else $error("irq dropped");
	a_pins_quiet: assert property (
		quiet == 4 |-> $stable(portaOut)) else $error("pins moved");
	cover property (irq);
	cover property (ar && aa == 8'h20 && !cmpW);
	cover property (!portaBit7OutEn_b && $changed(portaOut[7]));
endmodule // oc_pin_asserts

// File: tb/porta_load.sv
// External load on the port-A timer pins
`timescale 1ns/10ps
module porta_load (
	// Pins from the block
	input  wire logic [7:3] portaOut,
	input  wire logic       portaBit7OutEn_b,
	// Levels seen by the load
	output logic      [7:3] pinLevel
);
	// Bit 7 rests on its pull-up while it is an input
	assign pinLevel = {portaBit7OutEn_b ? 1'b1 : portaOut[7], portaOut[6:3]};
endmodule // porta_load

// File: tb/tb.sv
// Self-checking bench for the compare pin control block
`timescale 1ns/10ps
module tb;
	import oc_pin_pkg::*;
	logic clock = 0, rst_b = 0, hwrite = 0, hsel = 1, hready, hreadyout, hresp;
	logic irq, portaBit7OutEn_b, dir;
	logic [2:0] hsize = 3'h2;
	logic [1:0] htrans = 0;
	logic [7:0] haddr = 0, act, msk, dat;
	logic [31:0] hwdata = 0, hrdata, rd;
	logic [7:3] portaOut, pinLevel, pm = 0;
	int err_total = 0, num_checks = 0, seed = 32'h185271b5, t;
	assign hready = hreadyout;
	always #25 clock = ~clock;
	output_compare_pin_control u_output_compare_pin_control (.*);
	porta_load u_porta_load (.*);
	// One single word transfer; read data is taken at the closing edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hwrite <= w;
		haddr <= a;
		htrans <= 2'h2;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		while (hready !== 1'b1) @(posedge clock);
		rd = hrdata;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic give_verdict;
		if (err_total == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// A hang counts as a failure
	initial begin
		#3000000;
		err_total++;
		give_verdict;
	end
	initial begin
		repeat (12) @(posedge clock);
		rst_b <= 1;
		@(posedge clock);
		for (int a = 0; a < 20; a += 4) begin
			bus(0, 8'(a), 0);
			chk("reset value", 0, rd);
		end
		bus(0, 8'h20, 0);
		chk("compare reset", 16'hffff, rd[15:0]);
		bus(1, 8'h3c, 32'hffffffff);
		bus(0, 8'h3c, 0);
		chk("unmapped", 0, rd);
		bus(1, 8'h04, 32'hff);
		bus(0, 8'h04, 0);
		chk("mask low bits", 8'hf8, rd[7:0]);
		bus(1, 8'h10, 32'h1f);
		// All five channels match on one count; mask channel acts last
		for (int i = 0; i < 12; i++) begin
			t = $random(seed);
			{dir, act, msk, dat} = t[24:0];
			bus(1, 8'h00, act);
			bus(1, 8'h04, msk);
			bus(1, 8'h08, dat);
			bus(1, 8'h18, {dir, 7'h0});
			bus(0, 8'h14, 0);
			t = rd[15:0] + 60;
			for (int k = 0; k < 5; k++) bus(1, 8'(8'h20 + 4 * k), t[15:0]);
			while (irq !== 1'b1) @(posedge clock);
			repeat (3) @(posedge clock);
			for (int k = 1; k < 5; k++) begin
				case (act[9 - 2 * k -: 2])
					ACT_TOGGLE: pm[7 - k] = !pm[7 - k];
					ACT_CLEAR: pm[7 - k] = 0;
					ACT_SET: pm[7 - k] = 1;
					default: ;
				endcase
			end
			for (int b = 3; b < 8; b++) begin
				if (msk[b] && (b < 7 || dir)) pm[b] = dat[b];
			end
			chk("pins", {dir ? pm[7] : 1'b1, pm[6:3]}, pinLevel);
			chk("bit7 enable", !dir, portaBit7OutEn_b);
			bus(0, 8'h0c, 0);
			chk("flags", 5'h1f, rd[4:0]);
			chk("hresp", 0, hresp);
			bus(1, 8'h0c, 32'h1f);
			repeat (2) @(posedge clock);
			chk("irq", 0, irq);
		end
		give_verdict;
	end
endmodule // tb
bind output_compare_pin_control oc_pin_asserts u_oc_pin_asserts (.*);
